// [core/mpi_map.svh]
/*
 * Named constants for the multiply pipeline interlock: multiplier busy
 * lengths, counter width and reset values.
 * Assumes it is included by its bare name from the busy counter and interlock modules.
 */
`ifndef MPI_MAP_SVH
`define MPI_MAP_SVH

// ----------------------------------------------------------------------
// counter width in bits and multiplier busy lengths in clock cycles
// ----------------------------------------------------------------------
`define MPI_CNT_W 3
`define MPI_MM_WORD_MULTIPLY_ACCUMULATE 3'h2
`define MPI_MM_LONG_MULTIPLY_ACCUMULATE 3'h4
`define MPI_MM_SIGNED_WORD_MULTIPLY 3'h2
`define MPI_MM_SIGNED_DOUBLE_MULTIPLY 3'h4
`define MPI_MM_NONE 3'h0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MPI_RST_READY 1'b1
`define MPI_RST_FLAG 1'b0

`endif

// [core/mpi_pkg.sv]
/*
 * Types shared by the multiply pipeline interlock: instruction classes
 * and sequencer states.
 * Assumes the decoder classifies each issued instruction into mpi_op_t.
 */
package mpi_pkg;

	// ------------------------------------------------------------------
	// instruction classes seen at decode
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		OP_OTHER = 3'b000,
		OP_WORD_MULTIPLY_ACCUMULATE = 3'b001,
		OP_LONG_MULTIPLY_ACCUMULATE = 3'b010,
		OP_SIGNED_WORD_MULTIPLY = 3'b011,
		OP_SIGNED_DOUBLE_MULTIPLY = 3'b100,
		OP_SYS_REG = 3'b101,
		OP_SYS_REG_MEM = 3'b110
	} mpi_op_t;

	// ------------------------------------------------------------------
	// sequencer stages
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_EX = 3'b001,
		ST_MA1 = 3'b010,
		ST_MA2 = 3'b011,
		ST_HOLD = 3'b100
	} mpi_state_t;

endpackage

// [core/mpi_busy_counter.sv]
/*
 * Multiplier busy counter: loaded when a multiplier instruction leaves
 * its final memory stage, then counts down one per clock.
 * Assumes a synchronous active-low reset on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpi_map.svh"

module mpi_busy_counter
#(
	parameter int CNT_W = `MPI_CNT_W
)
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_load,
	input wire logic [CNT_W-1:0] i_load_val,
	output logic [CNT_W-1:0] o_count,
	output logic o_busy
);

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	generate
		if (CNT_W < `MPI_CNT_W)
		begin : g_bad_width
			$error("busy counter too narrow for longest busy period");
		end
	endgenerate

	logic [CNT_W-1:0] count_ff;
	logic busy_ff;

	// ------------------------------------------------------------------
	// count down; a fresh load wins over the running count
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			count_ff <= '0;
			busy_ff <= `MPI_RST_FLAG;
		end
		else if (i_load)
		begin
			count_ff <= i_load_val;
			busy_ff <= (i_load_val != '0);
		end
		else if (count_ff != '0)
		begin
			count_ff <= count_ff - 1'b1;
			busy_ff <= (count_ff > {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	assign o_count = count_ff;
	assign o_busy = busy_ff;

endmodule

`default_nettype wire

// [core/mpi_interlock.sv]
/*
 * Multiply pipeline interlock: sequences each multiplier-class
 * instruction from execute through its memory stages, splits slots
 * against instruction fetch and stretches stages on a multiplier still busy from a directly preceding accumulate.
 * Assumes the decoder presents one classified instruction at a time
 * and fetch raises i_fetch_req when it wants the memory bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpi_map.svh"

module mpi_interlock
	import mpi_pkg::*;
#(
	parameter int CNT_W = `MPI_CNT_W
)
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_issue_valid,
	input var mpi_op_t i_issue_op,
	input wire logic i_fetch_req,
	output logic o_issue_ready,
	output logic o_fetch_grant,
	output logic o_mem_access,
	output logic o_mult_access,
	output logic o_mult_stretch,
	output logic o_mult_busy,
	output var mpi_state_t o_stage
);

	// ------------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------------
	generate
		if (CNT_W < `MPI_CNT_W)
		begin : g_bad_width
			$error("interlock counter width too small");
		end
	endgenerate

	// ------------------------------------------------------------------
	// instruction class decoding
	// ------------------------------------------------------------------
	function automatic logic fn_needs_ma(input mpi_op_t op);
		fn_needs_ma = (op != OP_OTHER);
	endfunction

	function automatic logic fn_two_ma(input mpi_op_t op);
		fn_two_ma = (op == OP_WORD_MULTIPLY_ACCUMULATE) || (op == OP_LONG_MULTIPLY_ACCUMULATE);
	endfunction

	// stages that must wait for a running accumulate
	function automatic logic fn_mult_wait(input mpi_op_t op);
		fn_mult_wait = (op == OP_SIGNED_WORD_MULTIPLY) || (op == OP_SYS_REG) ||
			(op == OP_SYS_REG_MEM);
	endfunction

	function automatic logic fn_mult_user(input mpi_op_t op);
		fn_mult_user = (op != OP_OTHER);
	endfunction

	function automatic logic [CNT_W-1:0] fn_mm_load(input mpi_op_t op);
		case (op)
			OP_WORD_MULTIPLY_ACCUMULATE: fn_mm_load = CNT_W'(`MPI_MM_WORD_MULTIPLY_ACCUMULATE);
			OP_LONG_MULTIPLY_ACCUMULATE: fn_mm_load = CNT_W'(`MPI_MM_LONG_MULTIPLY_ACCUMULATE);
			OP_SIGNED_WORD_MULTIPLY: fn_mm_load = CNT_W'(`MPI_MM_SIGNED_WORD_MULTIPLY);
			OP_SIGNED_DOUBLE_MULTIPLY: fn_mm_load = CNT_W'(`MPI_MM_SIGNED_DOUBLE_MULTIPLY);
			default: fn_mm_load = CNT_W'(`MPI_MM_NONE);
		endcase
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	mpi_state_t state_ff;
	mpi_state_t nxt_state;
	mpi_op_t op_ff;
	logic split_ff;
	logic nxt_split;
	logic prev_mac_ff;
	logic ready_ff;
	logic fetch_ff;
	logic mem_ff;
	logic mult_ff;
	logic stretch_ff;
	logic nxt_fetch;
	logic nxt_mem;
	logic nxt_mult;
	logic nxt_stretch;
	logic mm_load;
	logic accept;
	logic busy_now;
	logic [CNT_W-1:0] mm_count;
	logic mm_busy;

	assign accept = i_issue_valid && ready_ff;
	assign busy_now = (mm_count != '0);

	mpi_busy_counter #(
		.CNT_W(CNT_W)
	) u_busy (
		.i_core_clk(i_core_clk),
		.i_reset_n(i_reset_n),
		.i_load(mm_load),
		.i_load_val(fn_mm_load(op_ff)),
		.o_count(mm_count),
		.o_busy(mm_busy)
	);

	// ------------------------------------------------------------------
	// stage sequencing
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_split = split_ff;
		nxt_mem = 1'b0;
		nxt_mult = 1'b0;
		nxt_stretch = 1'b0;
		mm_load = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				if (accept)
					nxt_state = ST_EX;
			end
			ST_EX:
			begin
				// plain instructions finish after execute, with no memory stage
				nxt_state = fn_needs_ma(op_ff) ? ST_MA1 : ST_IDLE;
			end
			ST_MA1:
			begin
				if (i_fetch_req && !split_ff)
				begin
					// fetch takes this half, access follows
					nxt_split = 1'b1;
				end
				else if (!fn_two_ma(op_ff) && fn_mult_wait(op_ff) &&
					busy_now && prev_mac_ff)
				begin
					// one stretched slot until the busy period ends
					nxt_stretch = 1'b1;
				end
				else
				begin
					nxt_split = 1'b0;
					// register-form moves touch only the multiplier
					nxt_mem = (op_ff != OP_SYS_REG);
					nxt_mult = !fn_two_ma(op_ff);
					if (fn_two_ma(op_ff))
						nxt_state = ST_MA2;
					else
					begin
						mm_load = 1'b1;
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_MA2:
			begin
				if (i_fetch_req && !split_ff)
					nxt_split = 1'b1;
				else
				begin
					// no wait on earlier busy stages
					nxt_split = 1'b0;
					nxt_mem = 1'b1;
					nxt_mult = 1'b1;
					mm_load = 1'b1;
					nxt_state = (op_ff == OP_LONG_MULTIPLY_ACCUMULATE) ? ST_HOLD : ST_IDLE;
				end
			end
			ST_HOLD:
			begin
				nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_fetch = i_fetch_req && !nxt_mem;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
			split_ff <= `MPI_RST_FLAG;
		else
			split_ff <= nxt_split;
	end

	// ------------------------------------------------------------------
	// issue bookkeeping
	// ------------------------------------------------------------------
	// only the directly preceding instruction counts, so any unrelated
	// instruction in between clears the contention history
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			op_ff <= OP_OTHER;
			prev_mac_ff <= `MPI_RST_FLAG;
		end
		else if (accept)
		begin
			op_ff <= i_issue_op;
			prev_mac_ff <= fn_two_ma(op_ff) && fn_mult_user(i_issue_op);
		end
	end

	// ------------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (!i_reset_n)
		begin
			ready_ff <= `MPI_RST_READY;
			fetch_ff <= `MPI_RST_FLAG;
			mem_ff <= `MPI_RST_FLAG;
			mult_ff <= `MPI_RST_FLAG;
			stretch_ff <= `MPI_RST_FLAG;
		end
		else
		begin
			ready_ff <= (nxt_state == ST_IDLE);
			fetch_ff <= nxt_fetch;
			mem_ff <= nxt_mem;
			mult_ff <= nxt_mult;
			stretch_ff <= nxt_stretch;
		end
	end

	assign o_issue_ready = ready_ff;
	assign o_fetch_grant = fetch_ff;
	assign o_mem_access = mem_ff;
	assign o_mult_access = mult_ff;
	assign o_mult_stretch = stretch_ff;
	assign o_mult_busy = mm_busy;
	assign o_stage = state_ff;

endmodule

`default_nettype wire

// [verification/mpi_interlock_props.sv]
/*
 * Port checker for the multiply pipeline interlock.
 * Assumes one core clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mpi_interlock_props
	import mpi_pkg::*;
#(
	parameter int CNT_W = 3
)
(
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_issue_valid,
	input var mpi_op_t i_issue_op,
	input wire logic i_fetch_req,
	input wire logic o_issue_ready,
	input wire logic o_fetch_grant,
	input wire logic o_mem_access,
	input wire logic o_mult_access,
	input wire logic o_mult_stretch,
	input wire logic o_mult_busy,
	input var mpi_state_t o_stage
);
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);

	property p_take_ex;
		i_issue_valid && o_issue_ready |=> o_stage == ST_EX;
	endproperty
	a_take_ex: assert property (p_take_ex) else $error("no execute");
	property p_ready_idle;
		o_issue_ready == (o_stage == ST_IDLE);
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("ready");
	property p_hold_one;
		o_stage == ST_HOLD |-> !o_issue_ready ##1 o_stage == ST_IDLE;
	endproperty
	a_hold_one: assert property (p_hold_one) else $error("hold");
	property p_hold_acc;
		o_stage == ST_HOLD |-> o_mult_access && o_mem_access;
	endproperty
	a_hold_acc: assert property (p_hold_acc) else $error("access");
	property p_busy_load;
		$rose(o_mult_busy) |-> o_mult_access;
	endproperty
	a_busy_load: assert property (p_busy_load) else $error("load");
	// a reload while busy restarts the count, so measure from each access
	property p_busy_len;
		o_mult_access ##1 !o_mult_access [*4] |-> !o_mult_busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy");
	property p_busy_min;
		$rose(o_mult_busy) |=> o_mult_busy;
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("short");
	property p_long_busy;
		o_stage == ST_HOLD |-> o_mult_busy [*4];
	endproperty
	a_long_busy: assert property (p_long_busy) else $error("busy4");
	property p_stretch;
		o_mult_stretch |-> !o_mult_access && !o_mem_access;
	endproperty
	a_stretch: assert property (p_stretch) else $error("stretch");
	property p_grant;
		o_fetch_grant |-> $past(i_fetch_req) && !o_mem_access;
	endproperty
	a_grant: assert property (p_grant) else $error("grant");
endmodule

bind mpi_interlock mpi_interlock_props #(.CNT_W(CNT_W)) u_props
(
	.i_core_clk, .i_reset_n, .i_issue_valid, .i_issue_op, .i_fetch_req,
	.o_issue_ready, .o_fetch_grant, .o_mem_access, .o_mult_access,
	.o_mult_stretch, .o_mult_busy, .o_stage
);

`default_nettype wire

// [verification/tb_top.sv]
/*
 * Self-checking bench for the multiply pipeline interlock.
 * Assumes the design files and the checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import mpi_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_issue_valid = 1'b0;
	logic i_fetch_req = 1'b0;
	mpi_op_t i_issue_op = OP_OTHER;
	logic o_issue_ready, o_fetch_grant, o_mem_access, o_mult_access;
	logic o_mult_stretch, o_mult_busy;
	mpi_state_t o_stage;
	int fails = 0;
	int checked = 0;
	int fmode = 0;
	int ntest = 0;
	int lost = 0;
	int fprev = 0;
	// 0 mem, 1 mult, 2 stretch, 3 busy, 4 hold
	int n[5] = '{0, 0, 0, 0, 0};
	int e_mem[7] = '{0, 2, 2, 1, 1, 0, 1};
	int e_mult[7] = '{0, 1, 1, 1, 1, 1, 1};
	int e_busy[7] = '{0, 2, 4, 2, 4, 0, 0};
	mpi_op_t q[$];

	always #5 i_core_clk = ~i_core_clk;

	mpi_interlock #(.CNT_W(3)) dut
	(
		.i_core_clk, .i_reset_n, .i_issue_valid, .i_issue_op, .i_fetch_req,
		.o_issue_ready, .o_fetch_grant, .o_mem_access, .o_mult_access,
		.o_mult_stretch, .o_mult_busy, .o_stage
	);

	// ------------------------------------------------------------------
	// monitor and fetch driver
	// ------------------------------------------------------------------
	always @(posedge i_core_clk)
	begin
		n[0] += int'(o_mem_access === 1'b1);
		n[1] += int'(o_mult_access === 1'b1);
		n[2] += int'(o_mult_stretch === 1'b1);
		n[3] += int'(o_mult_busy === 1'b1);
		n[4] += int'(o_stage === ST_HOLD);
		// a requested fetch is served unless a memory stage owns the bus
		lost += int'(fprev == 1 && o_fetch_grant !== 1'b1 &&
			o_mem_access !== 1'b1);
		fprev = int'(i_fetch_req === 1'b1);
		i_fetch_req <= (fmode == 2) || (fmode == 1 && $urandom_range(1, 0) == 1);
	end

	task automatic chk(input string nm, input int e, input int g);
		checked++;
		if (e != g)
		begin
			fails++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// issue the queued classes back to back, then compare with model
	// ------------------------------------------------------------------
	task automatic run(input int fm);
		int c0[5];
		int e[5];
		int k;
		int must;
		int none;
		mpi_op_t p;
		int l0;
		fmode = fm;
		c0 = n;
		l0 = lost;
		e = '{0, 0, 0, 0, 0};
		p = OP_OTHER;
		must = 0;
		none = 1;
		foreach (q[i])
		begin
			e[0] += e_mem[q[i]];
			e[1] += e_mult[q[i]];
			e[3] += e_busy[q[i]];
			e[4] += int'(q[i] == OP_LONG_MULTIPLY_ACCUMULATE);
			if (q[i] inside {OP_SIGNED_WORD_MULTIPLY, OP_SYS_REG, OP_SYS_REG_MEM})
			begin
				none = none & int'(!(p inside {OP_WORD_MULTIPLY_ACCUMULATE, OP_LONG_MULTIPLY_ACCUMULATE}));
				// a fetch split may use up the last busy cycle first
				must = must | int'(p == OP_LONG_MULTIPLY_ACCUMULATE && fm == 0);
			end
			p = q[i];
		end
		foreach (q[i])
		begin
			i_issue_valid <= 1'b1;
			i_issue_op <= q[i];
			k = 0;
			do
			begin
				@(posedge i_core_clk);
				k++;
			end while (o_issue_ready !== 1'b1 && k < 60);
			chk("take wait", 1, int'(k < 60));
		end
		i_issue_valid <= 1'b0;
		k = 0;
		do
		begin
			@(posedge i_core_clk);
			k++;
		end while (!(o_issue_ready === 1'b1 && o_mult_busy === 1'b0) && k < 60);
		repeat (2) @(posedge i_core_clk);
		chk("idle wait", 1, int'(k < 60));
		chk("mem pulses", e[0], n[0] - c0[0]);
		chk("fetch lost", 0, lost - l0);
		chk("mult pulses", e[1], n[1] - c0[1]);
		chk("hold cycles", e[4], n[4] - c0[4]);
		if (q.size() == 1)
			chk("busy cycles", e[3], n[3] - c0[3]);
		if (must == 1)
			chk("stretched", 1, int'(n[2] > c0[2]));
		if (none == 1)
			chk("stretch cycles", 0, n[2] - c0[2]);
		ntest++;
		$display("test %0d done", ntest);
		q.delete();
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		void'($urandom(74));
		repeat (3) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		@(posedge i_core_clk);
		chk("ready after reset", 1, int'(o_issue_ready === 1'b1));
		// every class alone, without and then with fetch contention
		for (int f = 0; f < 3; f += 2)
			for (int o = 0; o < 7; o++)
			begin
				q.push_back(mpi_op_t'(o));
				run(f);
			end
		q = {OP_LONG_MULTIPLY_ACCUMULATE, OP_SIGNED_WORD_MULTIPLY};
		run(0);
		q = {OP_LONG_MULTIPLY_ACCUMULATE, OP_SYS_REG};
		run(0);
		q = {OP_LONG_MULTIPLY_ACCUMULATE, OP_SYS_REG_MEM};
		run(0);
		q = {OP_LONG_MULTIPLY_ACCUMULATE, OP_OTHER, OP_SIGNED_WORD_MULTIPLY};
		run(0);
		q = {OP_LONG_MULTIPLY_ACCUMULATE, OP_SIGNED_DOUBLE_MULTIPLY};
		run(2);
		q = {OP_WORD_MULTIPLY_ACCUMULATE, OP_WORD_MULTIPLY_ACCUMULATE, OP_WORD_MULTIPLY_ACCUMULATE};
		run(1);
		q = {OP_WORD_MULTIPLY_ACCUMULATE, OP_LONG_MULTIPLY_ACCUMULATE, OP_OTHER};
		run(0);
		for (int r = 0; r < 4; r++)
		begin
			repeat (6) q.push_back(mpi_op_t'($urandom_range(6, 0)));
			run(1);
		end
		summarize();
	end

	// far beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		fails++;
		summarize();
	end
endmodule

`default_nettype wire
